//--- src/dts_pkg.sv
// Contract
// - current sensor fault trips with code ten
// - processor fault trips with code eleven
// - active external-fault terminal trips, code twelve
// - each terminal selectable normally-open or normally-closed
// - link external trip request also trips
// - guarded run at power-on trips, code thirteen
// - guard on by terminal or select 01
// - run check only in 2 s window
// - panel and link runs are also checked
// - power-up ground fault trips, code fourteen
// - ground check suppressed while tripped
// - ground check select can disable it
// - aux-first: ground check at main-on
package dts_pkg;

	// fault codes shown while tripped
	localparam logic [7:0] DTS_CODE_NONE = 8'h00;
	localparam logic [7:0] DTS_CODE_CUR  = 8'h0a;
	localparam logic [7:0] DTS_CODE_CPU  = 8'h0b;
	localparam logic [7:0] DTS_CODE_EXT  = 8'h0c;
	localparam logic [7:0] DTS_CODE_GUARD = 8'h0d;
	localparam logic [7:0] DTS_CODE_GND  = 8'h0e;

	// cause vector positions, lowest index has priority
	localparam int DTS_IDX_CUR = 0;
	localparam int DTS_IDX_CPU = 1;
	localparam int DTS_IDX_EXT = 2;
	localparam int DTS_IDX_GUARD = 3;
	localparam int DTS_IDX_GND = 4;
	localparam int DTS_N_CAUSE = 5;

	// selection values
	localparam logic [1:0] DTS_GUARD_ENABLE = 2'h1;
	localparam logic       DTS_GF_ENABLE    = 1'b1;

	// timing
	localparam int unsigned DTS_CLK_HZ          = 200_000_000;
	localparam int unsigned DTS_START_WINDOW_MS = 2000;
	localparam int unsigned DTS_START_WINDOW_CYC = DTS_START_WINDOW_MS * (DTS_CLK_HZ / 1000);
	localparam int unsigned DTS_GF_WINDOW_US    = 50;
	localparam int unsigned DTS_GF_WINDOW_CYC   = DTS_GF_WINDOW_US * (DTS_CLK_HZ / 1_000_000);

	// supervisor states
	typedef enum logic [0:0] {
		DTS_RUN  = 1'b0,
		DTS_TRIP = 1'b1
	} dts_state_t;

	// trip status carried together
	typedef struct packed {
		logic       tripped;
		logic [7:0] code;
	} dts_trip_t;

	localparam dts_trip_t DTS_TRIP_RESET = '{tripped: 1'b0, code: DTS_CODE_NONE};

endpackage

//--- src/dts_window_timer.sv
`timescale 1ns/1ps
// one-shot window: active for CYCLES clocks after start or reset
module dts_window_timer
	import dts_pkg::*;
#(
	parameter int unsigned CYCLES        = 16,
	parameter bit          LOAD_AT_RESET = 1'b0
) (
	// clock and reset
	input  wire logic i_clk,
	input  wire logic i_srst,
	// control
	input  wire logic i_start,
	// status
	output logic      o_active
);

	localparam int W = $clog2(CYCLES + 1);
	localparam logic [W-1:0] LOAD = W'(CYCLES);
	localparam logic [W-1:0] ZERO = '0;
	localparam logic [W-1:0] ONE  = W'(1);

	logic [W-1:0] count_reg;  // cycles left in the window

	// reload on start, count down to zero otherwise
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			count_reg <= LOAD_AT_RESET ? LOAD : ZERO;
		end else if (i_start) begin
			count_reg <= LOAD;
		end else if (count_reg != ZERO) begin
			count_reg <= count_reg - ONE;
		end
	end

	assign o_active = (count_reg != ZERO);

endmodule

//--- src/dts_supervisor.sv
`timescale 1ns/1ps
// protective trip supervisor for the drive power stage
module dts_supervisor
	import dts_pkg::*;
#(
	parameter int          N_TERM            = 8,
	parameter int unsigned START_WINDOW_CYCLES = DTS_START_WINDOW_CYC,
	parameter int unsigned GF_WINDOW_CYCLES    = DTS_GF_WINDOW_CYC
) (
	// clock and reset
	input  wire logic              I_CLK,
	input  wire logic              I_SRST,
	// internal monitors
	input  wire logic              I_CUR_SENSE_FAULT,
	input  wire logic              I_CPU_FAULT,
	input  wire logic              I_GROUND_FAULT,
	// input terminals and their configuration
	input  wire logic [N_TERM-1:0] I_TERM_IN,
	input  wire logic [N_TERM-1:0] I_TERM_NC,
	input  wire logic [N_TERM-1:0] I_EXTERNAL_FAULT_INPUT_SEL,
	input  wire logic [N_TERM-1:0] I_UNATTENDED_START_GUARD_SEL,
	// settings
	input  wire logic [1:0]        I_START_GUARD_SELECT,
	input  wire logic              I_GROUND_FAULT_CHECK_SELECT,
	// run commands and link trip
	input  wire logic              I_RUN_TERM,
	input  wire logic              I_RUN_PANEL,
	input  wire logic              I_RUN_COMM,
	input  wire logic              I_COMM_EXT_TRIP,
	// supplies
	input  wire logic              I_MAIN_PWR,
	input  wire logic              I_AUX24_PWR,
	// trip reset request
	input  wire logic              I_FAULT_RESET,
	// power stage and status
	output logic                   O_OUTPUT_EN,
	output dts_trip_t              O_TRIP,
	output logic                   O_START_WINDOW,
	output logic                   O_GF_CHECKING,
	output logic                   O_GF_WAIT_MAIN
);

	// pick the code of the highest-priority cause
	function automatic logic [7:0] dts_pick_code(input logic [DTS_N_CAUSE-1:0] c);
		logic [7:0] code;
		code = DTS_CODE_NONE;
		if (c[DTS_IDX_CUR]) begin
			code = DTS_CODE_CUR;
		end else if (c[DTS_IDX_CPU]) begin
			code = DTS_CODE_CPU;
		end else if (c[DTS_IDX_EXT]) begin
			code = DTS_CODE_EXT;
		end else if (c[DTS_IDX_GUARD]) begin
			code = DTS_CODE_GUARD;
		end else if (c[DTS_IDX_GND]) begin
			code = DTS_CODE_GND;
		end
		return code;
	endfunction

	logic [N_TERM-1:0]      term_active;     // terminal level after contact sense
	logic                   ext_term;        // any external-fault terminal active
	logic                   guard_term;      // any guard terminal active
	logic                   guard_on;        // unattended-start guard in force
	logic                   run_any;         // run from any source
	logic                   main_prev_reg;   // main supply last cycle
	logic                   main_rise;       // main supply just came on
	logic                   start_win;       // run-check window open
	logic                   gf_win;          // ground-check window open
	logic [DTS_N_CAUSE-1:0] cause;           // trip causes this cycle
	logic                   any_cause;       // at least one cause
	logic                   reset_ok;        // trip reset accepted
	dts_state_t             state_reg;       // supervisor state
	dts_state_t             state_next;
	dts_trip_t              trip_reg;        // latched status
	dts_trip_t              trip_next;
	logic                   out_en_reg;      // power stage enable
	logic                   wait_main_reg;   // aux up, main not yet
	logic                   srst_prev_reg;   // reset seen last cycle, for checks
	logic [31:0]            since_rst_reg;   // cycles since reset release, saturating

	// contact sense: a normally-closed terminal is active when open
	genvar g;
	generate
		for (g = 0; g < N_TERM; g++) begin : g_term
			assign term_active[g] = I_TERM_IN[g] ^ I_TERM_NC[g];
		end
	endgenerate

	// terminal function decode
	assign ext_term   = |(term_active & I_EXTERNAL_FAULT_INPUT_SEL);
	assign guard_term = |(term_active & I_UNATTENDED_START_GUARD_SEL);
	assign guard_on   = guard_term | (I_START_GUARD_SELECT == DTS_GUARD_ENABLE);
	assign run_any    = I_RUN_TERM | I_RUN_PANEL | I_RUN_COMM;

	// main supply edge; reset value zero makes a present supply count as a rise
	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			main_prev_reg <= 1'b0;
		end else begin
			main_prev_reg <= I_MAIN_PWR;
		end
	end
	assign main_rise = I_MAIN_PWR & ~main_prev_reg;

	// run-check window opens at power-on reset release
	dts_window_timer #(
		.CYCLES        (START_WINDOW_CYCLES),
		.LOAD_AT_RESET (1'b1)
	) u_start_win (
		.i_clk    (I_CLK),
		.i_srst   (I_SRST),
		.i_start  (1'b0),
		.o_active (start_win)
	);

	// ground-check window opens when the main supply comes on
	dts_window_timer #(
		.CYCLES        (GF_WINDOW_CYCLES),
		.LOAD_AT_RESET (1'b0)
	) u_gf_win (
		.i_clk    (I_CLK),
		.i_srst   (I_SRST),
		.i_start  (main_rise),
		.o_active (gf_win)
	);

	// trip causes
	always_comb begin
		cause = '0;
		cause[DTS_IDX_CUR] = I_CUR_SENSE_FAULT;
		cause[DTS_IDX_CPU] = I_CPU_FAULT;
		cause[DTS_IDX_EXT] = ext_term | I_COMM_EXT_TRIP;
		cause[DTS_IDX_GUARD] = start_win & guard_on & run_any;
		cause[DTS_IDX_GND] = gf_win & (I_GROUND_FAULT_CHECK_SELECT == DTS_GF_ENABLE)
			& I_GROUND_FAULT & (state_reg != DTS_TRIP);
	end
	assign any_cause = |cause;
	// a reset is taken only when nothing is still asking for a trip
	assign reset_ok  = I_FAULT_RESET & ~any_cause;

	// next state and latched code
	always_comb begin
		state_next = state_reg;
		trip_next  = trip_reg;
		case (state_reg)
			DTS_RUN: begin
				// first fault wins the recorded code
				if (any_cause) begin
					state_next        = DTS_TRIP;
					trip_next.tripped = 1'b1;
					trip_next.code    = dts_pick_code(cause);
				end
			end
			DTS_TRIP: begin
				// hold until reset accepted
				if (reset_ok) begin
					state_next = DTS_RUN;
					trip_next  = DTS_TRIP_RESET;
				end
			end
			default: begin
				state_next = DTS_TRIP;
				trip_next  = '{tripped: 1'b1, code: DTS_CODE_CPU};
			end
		endcase
	end

	// supervisor state
	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			state_reg <= DTS_RUN;
		end else begin
			state_reg <= state_next;
		end
	end

	// latched trip status
	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			trip_reg <= DTS_TRIP_RESET;
		end else begin
			trip_reg <= trip_next;
		end
	end

	// power stage enable drops with the trip
	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			out_en_reg <= 1'b0;
		end else begin
			out_en_reg <= (state_next == DTS_RUN);
		end
	end

	// aux supply up while main still absent: ground check deferred
	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			wait_main_reg <= 1'b0;
		end else begin
			wait_main_reg <= I_AUX24_PWR & ~I_MAIN_PWR;
		end
	end

	// reset delayed one cycle: the release edge still samples reset-time state,
	// so checks stay off until the first cycle that ran normally
	always_ff @(posedge I_CLK) begin
		srst_prev_reg <= I_SRST;
	end

	// cycles since reset release, stops once the run-check window has passed
	// so that it never wraps on the long default window
	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			since_rst_reg <= 32'h0;
		end else if (since_rst_reg < START_WINDOW_CYCLES) begin
			since_rst_reg <= since_rst_reg + 32'h1;
		end
	end

	// outputs
	assign O_OUTPUT_EN    = out_en_reg;
	assign O_TRIP         = trip_reg;
	assign O_START_WINDOW = start_win;
	assign O_GF_CHECKING  = gf_win;
	assign O_GF_WAIT_MAIN = wait_main_reg;

	// checks
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (I_SRST || srst_prev_reg);

	// running with no earlier cause
	sequence s_running;
		state_reg == DTS_RUN;
	endsequence

	// tripped output seen the next cycle
	sequence s_tripped_with(logic [7:0] c);
		##1 (trip_reg.tripped && !out_en_reg && trip_reg.code == c);
	endsequence

	a_cur_fault_trip: assert property (s_running and I_CUR_SENSE_FAULT
		|-> s_tripped_with(DTS_CODE_CUR)) else $error("current fault did not trip");

	a_cpu_fault_trip: assert property (s_running and (I_CPU_FAULT && !I_CUR_SENSE_FAULT)
		|-> s_tripped_with(DTS_CODE_CPU)) else $error("cpu fault did not trip");

	a_ext_term_trip: assert property (s_running and (ext_term && cause[1:0] == 2'h0)
		|-> s_tripped_with(DTS_CODE_EXT)) else $error("external terminal did not trip");

	a_nc_sense_bit: assert property ((I_EXTERNAL_FAULT_INPUT_SEL[0]
		&& (I_TERM_IN[0] != I_TERM_NC[0])) |=> trip_reg.tripped)
		else $error("terminal contact sense ignored");

	a_comm_trip: assert property (s_running and (I_COMM_EXT_TRIP && cause[1:0] == 2'h0)
		|-> s_tripped_with(DTS_CODE_EXT)) else $error("link trip ignored");

	a_guard_trip: assert property ((state_reg == DTS_RUN && start_win
		&& (I_START_GUARD_SELECT == DTS_GUARD_ENABLE) && I_RUN_PANEL && cause[2:0] == 3'h0)
		|=> trip_reg.code == DTS_CODE_GUARD) else $error("guarded run did not trip");

	a_window_closed: assert property (!start_win |=> !start_win)
		else $error("run-check window reopened");

	a_no_late_guard: assert property ((state_reg == DTS_RUN && !start_win
		&& cause[2:0] == 3'h0 && !cause[DTS_IDX_GND]) |=> !trip_reg.tripped)
		else $error("trip outside run-check window");

	a_gf_trip: assert property ((state_reg == DTS_RUN && gf_win && I_GROUND_FAULT
		&& I_GROUND_FAULT_CHECK_SELECT && cause[3:0] == 4'h0)
		|-> s_tripped_with(DTS_CODE_GND)) else $error("ground fault did not trip");

	a_gf_disabled: assert property ((state_reg == DTS_RUN && !I_GROUND_FAULT_CHECK_SELECT
		&& cause[3:0] == 4'h0) |=> !trip_reg.tripped) else $error("disabled ground check tripped");

	a_gf_main_edge: assert property ($rose(I_MAIN_PWR) |-> ##[0:1] gf_win)
		else $error("ground check not started at main-on");

	a_trip_hold: assert property ((trip_reg.tripped && !reset_ok)
		|=> (trip_reg.tripped && $stable(trip_reg.code) && !out_en_reg))
		else $error("trip not held");

	// a reset with every cause gone clears the code and frees the stage
	a_reset_accept: assert property ((trip_reg.tripped && I_FAULT_RESET && !any_cause)
		|=> (!trip_reg.tripped && out_en_reg && trip_reg.code == DTS_CODE_NONE))
		else $error("trip reset not accepted");

	// a ground fault seen while tripped must not hold the trip
	a_gf_masked_trip: assert property ((trip_reg.tripped && I_FAULT_RESET && gf_win
		&& I_GROUND_FAULT && I_GROUND_FAULT_CHECK_SELECT && cause[3:0] == 4'h0)
		|=> !trip_reg.tripped) else $error("ground check active while tripped");

	// aux supply alone never opens the ground-check window
	a_aux_no_check: assert property ((I_AUX24_PWR && !I_MAIN_PWR && !gf_win)
		|=> !gf_win) else $error("ground check started by aux supply");

	// guard enabled by its terminal, run from the link
	a_guard_term_trip: assert property ((state_reg == DTS_RUN && start_win
		&& guard_term && I_RUN_COMM && cause[2:0] == 3'h0)
		|=> trip_reg.code == DTS_CODE_GUARD) else $error("terminal guard did not trip");

	// run-check window spans exactly its length from reset release
	a_window_span: assert property (start_win == (since_rst_reg < START_WINDOW_CYCLES))
		else $error("run-check window length wrong");

endmodule

//--- verification/dts_ctrl_model.sv
`timescale 1ns/1ps
// far side: controller equipment driving terminals and run commands
module dts_ctrl_model (
	// clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_srst,
	// requests from the bench
	input  wire logic [2:0] i_run_req,
	input  wire logic       i_early,
	input  wire logic [7:0] i_act,
	input  wire logic [7:0] i_nc,
	// start window seen at the device
	input  wire logic       i_window,
	// lines to the device
	output logic      [2:0] o_run,
	output logic      [7:0] o_term
);
	// runs stay released while the device starts, unless told to misbehave
	always_ff @(posedge i_clk) begin
		if (i_early) begin
			o_run <= i_run_req;
		end else if (i_srst || i_window) begin
			o_run <= 3'h0;
		end else begin
			o_run <= i_run_req;
		end
	end
	// contact sense: a normally-closed contact reads low while active
	always_ff @(posedge i_clk) begin
		o_term <= i_act ^ i_nc;
	end
endmodule

//--- verification/dts_supervisor_tb_top.sv
`timescale 1ns/1ps
// self-checking bench for the trip supervisor
module dts_supervisor_tb_top
	import dts_pkg::*;
;
	localparam int SW = 50; // shortened start window
	localparam int GW = 20; // shortened ground window
	// stimulus, defined at time zero except run and term, set by the controller model at its first edge
	logic       clk = 1'b0, srst = 1'b1, cur = 1'b0, cpu = 1'b0, gnd = 1'b0;
	logic       comm_trip = 1'b0, main = 1'b0, aux = 1'b0, frst = 1'b0;
	logic       gfsel = 1'b1, early = 1'b0;
	logic [1:0] gsel = 2'h0;
	logic [2:0] run_req = 3'h0, run;
	logic [7:0] nc = 8'h00, act = 8'h00, term;
	// observed outputs
	logic       out_en, swin, gfchk, gfwait;
	dts_trip_t  trip;
	int         fails = 0;
	int         n_checks = 0;

	// 200 MHz clock
	always #2.5 clk = ~clk;

	dts_ctrl_model u_ctrl (.i_clk(clk), .i_srst(srst), .i_run_req(run_req), .i_early(early),
		.i_act(act), .i_nc(nc), .i_window(swin), .o_run(run), .o_term(term));

	dts_supervisor #(.START_WINDOW_CYCLES(SW), .GF_WINDOW_CYCLES(GW)) u_dut (
		.I_CLK(clk), .I_SRST(srst), .I_CUR_SENSE_FAULT(cur), .I_CPU_FAULT(cpu),
		.I_GROUND_FAULT(gnd), .I_TERM_IN(term), .I_TERM_NC(nc),
		.I_EXTERNAL_FAULT_INPUT_SEL(8'h01), .I_UNATTENDED_START_GUARD_SEL(8'h02),
		.I_START_GUARD_SELECT(gsel), .I_GROUND_FAULT_CHECK_SELECT(gfsel),
		.I_RUN_TERM(run[0]), .I_RUN_PANEL(run[1]), .I_RUN_COMM(run[2]),
		.I_COMM_EXT_TRIP(comm_trip), .I_MAIN_PWR(main), .I_AUX24_PWR(aux),
		.I_FAULT_RESET(frst), .O_OUTPUT_EN(out_en), .O_TRIP(trip),
		.O_START_WINDOW(swin), .O_GF_CHECKING(gfchk), .O_GF_WAIT_MAIN(gfwait));

	// counts and verdict, the single end of the run
	task automatic end_of_test();
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// let n edges pass, then settle
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// trip status together with the power stage enable
	task automatic chk_trip(input logic t, input logic [7:0] c);
		n_checks++;
		if (trip !== {t, c} || out_en !== ~t) begin
			fails++;
			$display("ERROR %0t trip %h en %b want %b %h", $time, trip, out_en, t, c);
		end
	endtask
	// a single status flag
	task automatic chk_bit(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t flag %b want %b", $time, got, exp);
		end
	endtask
	// reset pulse of five clocks, ends one edge after release
	task automatic do_reset();
		@(posedge clk);
		srst <= 1'b1;
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		step(1);
	endtask
	// clear a latched trip once its causes are gone
	task automatic clear_trip();
		@(posedge clk);
		frst <= 1'b1;
		step(3);
		@(posedge clk);
		frst <= 1'b0;
		step(1);
		chk_trip(1'b0, DTS_CODE_NONE);
	endtask
	// raise or drop one fault source, or current and cpu together
	task automatic set_src(input int i, input logic v);
		case (i)
			0: cur <= v;
			1: cpu <= v;
			2: act[0] <= v;
			3: begin
				nc[0] <= 1'b1;
				act[0] <= v;
			end
			4: comm_trip <= v;
			default: begin
				cur <= v;
				cpu <= v;
			end
		endcase
	endtask
	// each source trips with its code; later faults and early resets change nothing
	task automatic sc_faults();
		logic [7:0] codes [6];
		codes = '{DTS_CODE_CUR, DTS_CODE_CPU, DTS_CODE_EXT, DTS_CODE_EXT,
			DTS_CODE_EXT, DTS_CODE_CUR};
		for (int i = 0; i < 6; i++) begin
			@(posedge clk);
			set_src(i, 1'b1);
			step(3);
			chk_trip(1'b1, codes[i]);
			@(posedge clk);
			if (i == 0) begin
				cpu <= 1'b1;
			end else begin
				cur <= 1'b1;
			end
			frst <= 1'b1;
			step(3);
			chk_trip(1'b1, codes[i]);
			@(posedge clk);
			cur <= 1'b0;
			cpu <= 1'b0;
			if (i > 1 && i < 5) begin
				set_src(i, 1'b0);
			end
			step(4);
			chk_trip(1'b0, DTS_CODE_NONE);
			@(posedge clk);
			frst <= 1'b0;
		end
	endtask
	// run at power-on against the guard settings and the start window
	task automatic sc_guard(input logic [1:0] s, input logic tg, input logic [2:0] r,
		input logic e, input logic exp);
		@(posedge clk);
		gsel <= s;
		act[1] <= tg;
		run_req <= r;
		early <= e;
		do_reset();
		step(SW - 4);
		chk_bit(swin, 1'b1);
		step(6);
		chk_bit(swin, 1'b0);
		step(3);
		chk_trip(exp, exp ? DTS_CODE_GUARD : DTS_CODE_NONE);
		@(posedge clk);
		run_req <= 3'h0;
		early <= 1'b0;
		act[1] <= 1'b0;
		gsel <= 2'h0;
		clear_trip();
	endtask
	// ground check opens at main-on, aux first
	task automatic sc_gnd(input logic f, input logic pre, input int d, input logic [7:0] c);
		@(posedge clk);
		gfsel <= f;
		aux <= 1'b1;
		cpu <= pre;
		step(3);
		chk_bit(gfwait, 1'b1);
		chk_bit(gfchk, 1'b0);
		@(posedge clk);
		main <= 1'b1;
		step(2);
		chk_bit(gfchk, 1'b1);
		step(d);
		@(posedge clk);
		gnd <= 1'b1;
		step(3);
		chk_trip(c != DTS_CODE_NONE, c);
		@(posedge clk);
		gnd <= 1'b0;
		cpu <= 1'b0;
		main <= 1'b0;
		aux <= 1'b0;
		step(GW);
		clear_trip();
	endtask

	// main sequence
	initial begin
		step(4);
		chk_bit(out_en, 1'b0);
		chk_bit(swin, 1'b1);
		@(posedge clk);
		srst <= 1'b0;
		step(2);
		chk_trip(1'b0, DTS_CODE_NONE);
		step(SW);
		sc_faults();
		sc_guard(2'h1, 1'b0, 3'h2, 1'b1, 1'b1);
		sc_guard(2'h0, 1'b1, 3'h4, 1'b1, 1'b1);
		sc_guard(2'h2, 1'b0, 3'h1, 1'b1, 1'b0);
		sc_guard(2'h1, 1'b0, 3'h1, 1'b0, 1'b0);
		sc_gnd(1'b1, 1'b0, 0, DTS_CODE_GND);
		sc_gnd(1'b0, 1'b0, 0, DTS_CODE_NONE);
		sc_gnd(1'b1, 1'b1, 0, DTS_CODE_CPU);
		sc_gnd(1'b1, 1'b0, GW + 2, DTS_CODE_NONE);
		end_of_test();
	end
	// watchdog against a hung run
	initial begin
		#200000;
		fails++;
		end_of_test();
	end
endmodule
